// ==== dv/pmos_core_model.sv ====
// Purpose: Core write port and wake pins model
// Assumes: Writes come in pairs, on adjacent cycles or with one idle cycle between
// Notes: Pins pulled up, data inverted after a pair
`default_nettype none
module pmos_core_model (
    input wire logic clk,
    output logic wr_en,
    output logic [7:0] wr_data,
    output logic wake0,
    output logic wake1
);
    timeunit 1ns;
    timeprecision 1ps;
    initial begin
        wr_en = 1'b0;
        wr_data = 8'hFF;
        wake0 = 1'b1;
        wake1 = 1'b1;
    end
    // Second write right after the first
    task pair(input logic [7:0] a, input logic [7:0] b);
        @(posedge clk) wr_en <= 1'b1;
        wr_data <= a;
        @(posedge clk) wr_data <= b;
        @(posedge clk) wr_en <= 1'b0;
        wr_data <= ~b;
    endtask : pair
    // Gap between the two writes
    task split(input logic [7:0] a, input logic [7:0] b);
        @(posedge clk) wr_en <= 1'b1;
        wr_data <= a;
        @(posedge clk) wr_en <= 1'b0;
        @(posedge clk) wr_en <= 1'b1;
        wr_data <= b;
        @(posedge clk) wr_en <= 1'b0;
    endtask : split
    // Short low pulse, pull-up restores high
    task pulse(input logic sel);
        @(posedge clk) {wake1, wake0} <= sel ? 2'b01 : 2'b10;
        repeat (3) @(posedge clk);
        {wake1, wake0} <= 2'b11;
    endtask : pulse
endmodule : pmos_core_model
`default_nettype wire

// ==== dv/tb.sv ====
// Purpose: Self-checking bench for the power mode supervisor
// Assumes: Short stabilization count
// Notes: Waits are fixed spans beyond the count
`default_nettype none
module tb;
    timeunit 1ns;
    timeprecision 1ps;
    localparam int S = 20;
    logic sys_clk = 0, reset_n = 0, mof = 0, irq = 0, we, w0, w1;
    logic [7:0] wd, pcr, d;
    logic cr, rc, mo, ro, ce, pe, wi, wh;
    int fail_count = 0, checked = 0, seed = 32'h6b58;
    int n_ce, n_pe, n_wi = 0;
    always @(posedge sys_clk) if (wi === 1'b1) n_wi <= n_wi + 1;
    pmos_core_model u_pmos_core_model (.clk(sys_clk), .wr_en(we), .wr_data(wd), .wake0(w0),
        .wake1(w1));
    pmos_supervisor #(.STAB_CYCLES(S)) u_pmos_supervisor (.sys_clk(sys_clk), .reset_n(reset_n),
        .pwr_wr_en(we), .pwr_wr_data(wd), .main_osc_faster(mof), .periph_irq(irq),
        .ext_irq0_wake_pin(w0), .can_rx_wake_pin(w1), .power_control_reg(pcr),
        .cpu_reset(cr), .clk_sel_rc(rc), .main_osc_en(mo), .rc_osc_en(ro), .cpu_clk_en(ce),
        .periph_clk_en(pe), .pd_wake_irq(wi), .wdt_halt(wh));
    initial forever #4 sys_clk = ~sys_clk;
    task count_en(input int n);
        n_ce = 0;
        n_pe = 0;
        repeat (n) begin
            @(posedge sys_clk);
            n_ce += ce;
            n_pe += pe;
        end
    endtask : count_en
    task chk(input logic [15:0] g, input logic [15:0] e);
        checked++;
        if (g !== e) begin
            fail_count++;
            $display("unexpected t=%0t got=%h exp=%h", $time, g, e);
        end
    endtask : chk
    task final_report;
        if (fail_count == 0 && checked > 0) $display("NO MISMATCHES");
        else $display("MISMATCHES SEEN");
        $finish;
    endtask : final_report
    initial begin
        repeat (16) @(posedge sys_clk);
        reset_n <= 1;
        repeat (40) @(posedge sys_clk);
        chk({cr, rc}, 2'b11);
        mof <= 1;
        repeat (S + 20) @(posedge sys_clk);
        chk({cr, rc, pcr}, 0);
        u_pmos_core_model.split(8'h01, 8'h20);
        repeat (4) @(posedge sys_clk);
        chk({wh, pcr}, 0);
        u_pmos_core_model.pair(8'h01, 8'h20);
        repeat (4) @(posedge sys_clk);
        chk({ce, pe, wh}, 3'b011);
        irq <= 1;
        repeat (4) @(posedge sys_clk);
        irq <= 0;
        chk(ce, 1);
        u_pmos_core_model.pair(8'h02, 8'h40);
        repeat (4) @(posedge sys_clk);
        chk({mo, ro, wh}, 3'b001);
        u_pmos_core_model.pulse($random(seed));
        repeat (S + 30) @(posedge sys_clk);
        chk({mo, ro, ce, rc}, 4'b1110);
        chk(n_wi, 1);
        d = 8'h10 | ($random(seed) & 8'h80);
        u_pmos_core_model.pair(d, d);
        repeat (4) @(posedge sys_clk);
        chk(pcr[4], 1);
        count_en(64);
        chk({n_ce[7:0], n_pe[7:0]}, 16'h0202);
        u_pmos_core_model.pair(d | 8'h01, d | 8'h20);
        repeat (4) @(posedge sys_clk);
        count_en(64);
        chk({n_ce[7:0], n_pe[7:0]}, 16'h0002);
        irq <= 1;
        repeat (4) @(posedge sys_clk);
        irq <= 0;
        u_pmos_core_model.pair(d & 8'hEF, d & 8'hEF);
        repeat (4) @(posedge sys_clk);
        chk(pcr[4], 0);
        u_pmos_core_model.pair(d, d);
        repeat (4) @(posedge sys_clk);
        reset_n <= 0;
        repeat (4) @(posedge sys_clk);
        reset_n <= 1;
        repeat (S + 20) @(posedge sys_clk);
        chk({cr, pcr}, 0);
        mof <= 0;
        repeat (4) @(posedge sys_clk);
        chk({cr, rc, mo}, 3'b111);
        mof <= 1;
        repeat (S + 20) @(posedge sys_clk);
        chk({cr, rc}, 0);
        final_report();
    end
    initial begin
        repeat (5000) @(posedge sys_clk);
        fail_count++;
        final_report();
    end
endmodule : tb
`default_nettype wire

// ==== rtl/pmos_pkg.sv ====
// Purpose: Shared constants for the power mode and oscillator supervisor
// Assumes: 125 MHz system clock
// Notes: Bit positions refer to the power control register
`default_nettype none
package pmos_pkg;
    localparam int unsigned CLK_FREQ_KHZ = 125000;
    localparam int unsigned STAB_TIME_US = 1000;
    localparam int unsigned STAB_CYCLES = (STAB_TIME_US * CLK_FREQ_KHZ) / 1000;
    localparam int unsigned STAB_CNT_W = 17;
    localparam int unsigned SLOW_DIV = 32;

    localparam int unsigned IDLE_ARM_BIT = 0;
    localparam int unsigned PD_ARM_BIT = 1;
    localparam int unsigned SLOW_BIT = 4;
    localparam int unsigned IDLE_GO_BIT = 5;
    localparam int unsigned PD_GO_BIT = 6;
    localparam logic [7:0] PWR_CTL_RESET = 8'h00;
    localparam logic [7:0] PWR_CTL_KEEP_MASK = 8'h8C;

    typedef enum logic [2:0] {
        PMOS_RESET = 3'h0,
        PMOS_STAB = 3'h1,
        PMOS_RUN = 3'h3,
        PMOS_IDLE = 3'h2,
        PMOS_PDOWN = 3'h6,
        PMOS_WAKE = 3'h7,
        PMOS_WSTAB = 3'h5
    } pmos_state_e;
endpackage : pmos_pkg
`default_nettype wire

// ==== rtl/pmos_slow_div.sv ====
// Purpose: Clock enable strobe, full rate or divided
// Assumes: Single clock domain, synchronous inputs
// Notes: Strobe is held low while run is low
`default_nettype none
module pmos_slow_div #(
    parameter int unsigned DIV = pmos_pkg::SLOW_DIV
) (
    input wire logic clk,
    input wire logic rst_n,
    input wire logic run,
    input wire logic slow,
    output logic tick
);
    localparam int unsigned CW = $clog2(DIV);
    localparam logic [CW-1:0] LAST = CW'(DIV - 1);

    logic [CW-1:0] cnt_q;
    logic [CW-1:0] cnt_d;
    logic tick_q;
    logic tick_d;
    logic wrap;

    assign wrap = (cnt_q == LAST);
    assign cnt_d = (!run || wrap) ? '0 : cnt_q + CW'(1);
    // Divided strobe keeps full functionality at 1/DIV rate
    assign tick_d = run && (!slow || wrap);
    assign tick = tick_q;

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            cnt_q <= '0;
            tick_q <= 1'b0;
        end else begin
            cnt_q <= cnt_d;
            tick_q <= tick_d;
        end
    end
endmodule : pmos_slow_div
`default_nettype wire

// ==== rtl/pmos_supervisor.sv ====
// Purpose: Idle, power-down and slow-down control with oscillator supervision
// Assumes: Core presents full register value on each power control write
// Notes: Oscillator comparison arrives as a synchronous level
//
// What this block does
// - Reset sequence runs on RC clock before the main oscillator starts.
// - Power-on reset holds while main oscillator is slower than RC.
// - Low on either wake pin leaves power-down; resume on nominal clock.
// - Power-down stops both oscillators; release restarts both.
// - After wake, main faster than RC, wait 1 ms, then wake interrupt.
// - Idle keeps oscillator and peripheral clock, gates CPU clock.
// - Idle ends on enabled peripheral interrupt or hardware reset.
// - Power-down halts everything with oscillator off, state retained.
// - Power-down ends on hardware reset or low pulse on a wake pin.
// - Slow-down divides CPU and peripheral clock by 32.
// - Slow-down set by bit 10H, cleared by 0EFH mask or reset.
// - Slow-down division stays in force during idle.
// - Main slower than RC forces RC clock and reset in run, idle and reset states, 1 ms tail.
// - Watchdog timer halts during idle and power-down.
`default_nettype none
module pmos_supervisor #(
    parameter int unsigned STAB_CYCLES = pmos_pkg::STAB_CYCLES,
    parameter int unsigned CNT_W = pmos_pkg::STAB_CNT_W
) (
    input wire logic sys_clk,
    input wire logic reset_n,
    input wire logic pwr_wr_en,
    input wire logic [7:0] pwr_wr_data,
    input wire logic main_osc_faster,
    input wire logic periph_irq,
    input wire logic ext_irq0_wake_pin,
    input wire logic can_rx_wake_pin,
    output logic [7:0] power_control_reg,
    output logic cpu_reset,
    output logic clk_sel_rc,
    output logic main_osc_en,
    output logic rc_osc_en,
    output logic cpu_clk_en,
    output logic periph_clk_en,
    output logic pd_wake_irq,
    output logic wdt_halt
);
    localparam logic [CNT_W-1:0] STAB_LAST = CNT_W'(STAB_CYCLES - 1);

    logic rst_meta_q;
    logic rst_sync_q;
    logic rst_n;

    // Async assert, synchronous release through two stages
    always_ff @(posedge sys_clk or negedge reset_n) begin
        if (!reset_n) begin
            rst_meta_q <= 1'b0;
            rst_sync_q <= 1'b0;
        end else begin
            rst_meta_q <= 1'b1;
            rst_sync_q <= rst_meta_q;
        end
    end
    assign rst_n = rst_sync_q;

    // Plain storage bits plus the slow-down bit survive writes and power-down
    localparam logic [7:0] STORE_MASK = pmos_pkg::PWR_CTL_KEEP_MASK |
        (8'h01 << pmos_pkg::SLOW_BIT);

    pmos_pkg::pmos_state_e state_q;
    pmos_pkg::pmos_state_e state_d;
    logic [CNT_W-1:0] stab_cnt_q;
    logic [CNT_W-1:0] stab_cnt_d;
    logic [7:0] pcr_q;
    logic [7:0] pcr_d;
    logic [7:0] keep_d;
    logic cpu_reset_q;
    logic cpu_reset_d;
    logic clk_sel_rc_q;
    logic clk_sel_rc_d;
    logic main_osc_en_q;
    logic rc_osc_en_q;
    logic osc_en_d;
    logic cpu_clk_en_q;
    logic cpu_clk_en_d;
    logic periph_clk_en_q;
    logic periph_clk_en_d;
    logic pd_wake_irq_q;
    logic pd_wake_irq_d;
    logic wdt_halt_q;
    logic wdt_halt_d;
    logic wr_run;
    logic arm_ok;
    logic idle_enter;
    logic pd_enter;
    logic wake_low;
    logic counting;
    logic stab_done;
    logic tick;

    // Reset sequencing covers the RC phase and the stabilization tail
    function automatic logic is_reset(input pmos_pkg::pmos_state_e s);
        return (s == pmos_pkg::PMOS_RESET) || (s == pmos_pkg::PMOS_STAB);
    endfunction : is_reset

    function automatic logic cpu_runs(input pmos_pkg::pmos_state_e s);
        return (s == pmos_pkg::PMOS_RUN) || is_reset(s);
    endfunction : cpu_runs

    function automatic logic periph_runs(input pmos_pkg::pmos_state_e s);
        return cpu_runs(s) || (s == pmos_pkg::PMOS_IDLE);
    endfunction : periph_runs

    // Wake phases still count as power-down for the watchdog timer
    function automatic logic is_halted(input pmos_pkg::pmos_state_e s);
        return (s == pmos_pkg::PMOS_IDLE) || (s == pmos_pkg::PMOS_PDOWN) ||
            (s == pmos_pkg::PMOS_WAKE) || (s == pmos_pkg::PMOS_WSTAB);
    endfunction : is_halted

    // Writes only count while the core executes
    assign wr_run = pwr_wr_en && (state_q == pmos_pkg::PMOS_RUN);
    // Go bit needs the arm bit written on the cycle before
    assign idle_enter = wr_run && pwr_wr_data[pmos_pkg::IDLE_GO_BIT] &&
        pcr_q[pmos_pkg::IDLE_ARM_BIT];
    assign pd_enter = wr_run && pwr_wr_data[pmos_pkg::PD_GO_BIT] &&
        pcr_q[pmos_pkg::PD_ARM_BIT];
    assign arm_ok = wr_run && (state_d == pmos_pkg::PMOS_RUN);
    // Level wake, no edge detect, so no false wake after reset
    assign wake_low = !ext_irq0_wake_pin || !can_rx_wake_pin;

    assign counting = (state_q == pmos_pkg::PMOS_STAB) || (state_q == pmos_pkg::PMOS_WSTAB);
    assign stab_done = counting && (stab_cnt_q == STAB_LAST);
    assign stab_cnt_d = (counting && !stab_done) ? stab_cnt_q + CNT_W'(1) : '0;

    always_comb begin
        state_d = state_q;
        case (state_q)
            pmos_pkg::PMOS_RESET: begin
                // RC clock drives reset until main oscillator overtakes it
                if (main_osc_faster) begin
                    state_d = pmos_pkg::PMOS_STAB;
                end
            end
            pmos_pkg::PMOS_STAB: begin
                // Reset tail of the stabilization count, then restart at zero
                if (!main_osc_faster) begin
                    state_d = pmos_pkg::PMOS_RESET;
                end else if (stab_done) begin
                    state_d = pmos_pkg::PMOS_RUN;
                end
            end
            pmos_pkg::PMOS_RUN: begin
                if (!main_osc_faster) begin
                    state_d = pmos_pkg::PMOS_RESET;
                end else if (pd_enter) begin
                    state_d = pmos_pkg::PMOS_PDOWN;
                end else if (idle_enter) begin
                    state_d = pmos_pkg::PMOS_IDLE;
                end
            end
            pmos_pkg::PMOS_IDLE: begin
                if (!main_osc_faster) begin
                    state_d = pmos_pkg::PMOS_RESET;
                end else if (periph_irq) begin
                    state_d = pmos_pkg::PMOS_RUN;
                end
            end
            pmos_pkg::PMOS_PDOWN: begin
                // Oscillators are off, so the comparison is ignored here
                if (wake_low) begin
                    state_d = pmos_pkg::PMOS_WAKE;
                end
            end
            pmos_pkg::PMOS_WAKE: begin
                if (main_osc_faster) begin
                    state_d = pmos_pkg::PMOS_WSTAB;
                end
            end
            pmos_pkg::PMOS_WSTAB: begin
                // A drop during the tail restarts the wait rather than resetting
                if (!main_osc_faster) begin
                    state_d = pmos_pkg::PMOS_WAKE;
                end else if (stab_done) begin
                    state_d = pmos_pkg::PMOS_RUN;
                end
            end
            default: begin
                state_d = pmos_pkg::PMOS_RESET;
            end
        endcase
    end

    // Any reset state clears slow-down and pending requests
    assign keep_d = is_reset(state_d) ? pmos_pkg::PWR_CTL_RESET :
        (wr_run ? (pwr_wr_data & STORE_MASK) : (pcr_q & STORE_MASK));

    always_comb begin
        pcr_d = keep_d;
        pcr_d[pmos_pkg::IDLE_ARM_BIT] = arm_ok && pwr_wr_data[pmos_pkg::IDLE_ARM_BIT];
        pcr_d[pmos_pkg::PD_ARM_BIT] = arm_ok && pwr_wr_data[pmos_pkg::PD_ARM_BIT];
        pcr_d[pmos_pkg::IDLE_GO_BIT] = (state_d == pmos_pkg::PMOS_IDLE);
        pcr_d[pmos_pkg::PD_GO_BIT] = (state_d == pmos_pkg::PMOS_PDOWN);
    end

    assign cpu_reset_d = is_reset(state_d);
    assign clk_sel_rc_d = (state_d == pmos_pkg::PMOS_RESET) || (state_d == pmos_pkg::PMOS_WAKE);
    // Both oscillators share one enable
    assign osc_en_d = (state_d != pmos_pkg::PMOS_PDOWN);
    // Divided strobe gates CPU and peripherals alike, also in idle
    assign cpu_clk_en_d = tick && cpu_runs(state_d);
    assign periph_clk_en_d = tick && periph_runs(state_d);
    assign pd_wake_irq_d = (state_q == pmos_pkg::PMOS_WSTAB) && (state_d == pmos_pkg::PMOS_RUN);
    assign wdt_halt_d = is_halted(state_d);

    pmos_slow_div #(
        .DIV(pmos_pkg::SLOW_DIV)
    ) u_pmos_slow_div (
        .clk(sys_clk),
        .rst_n(rst_n),
        .run(main_osc_en_q),
        .slow(pcr_q[pmos_pkg::SLOW_BIT]),
        .tick(tick)
    );

    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            state_q <= pmos_pkg::PMOS_RESET;
            stab_cnt_q <= '0;
            pcr_q <= pmos_pkg::PWR_CTL_RESET;
        end else begin
            state_q <= state_d;
            stab_cnt_q <= stab_cnt_d;
            pcr_q <= pcr_d;
        end
    end

    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            cpu_reset_q <= 1'b1;
            clk_sel_rc_q <= 1'b1;
            main_osc_en_q <= 1'b1;
            rc_osc_en_q <= 1'b1;
        end else begin
            cpu_reset_q <= cpu_reset_d;
            clk_sel_rc_q <= clk_sel_rc_d;
            main_osc_en_q <= osc_en_d;
            rc_osc_en_q <= osc_en_d;
        end
    end

    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            cpu_clk_en_q <= 1'b0;
            periph_clk_en_q <= 1'b0;
            pd_wake_irq_q <= 1'b0;
            wdt_halt_q <= 1'b0;
        end else begin
            cpu_clk_en_q <= cpu_clk_en_d;
            periph_clk_en_q <= periph_clk_en_d;
            pd_wake_irq_q <= pd_wake_irq_d;
            wdt_halt_q <= wdt_halt_d;
        end
    end

    assign power_control_reg = pcr_q;
    assign cpu_reset = cpu_reset_q;
    assign clk_sel_rc = clk_sel_rc_q;
    assign main_osc_en = main_osc_en_q;
    assign rc_osc_en = rc_osc_en_q;
    assign cpu_clk_en = cpu_clk_en_q;
    assign periph_clk_en = periph_clk_en_q;
    assign pd_wake_irq = pd_wake_irq_q;
    assign wdt_halt = wdt_halt_q;

    default clocking cb_sys @(posedge sys_clk);
    endclocking
    default disable iff (!rst_n);

    sequence s_idle_arm;
        wr_run && pwr_wr_data[pmos_pkg::IDLE_ARM_BIT] && main_osc_faster;
    endsequence
    sequence s_idle_go;
        wr_run && pwr_wr_data[pmos_pkg::IDLE_GO_BIT] && !pwr_wr_data[pmos_pkg::PD_GO_BIT] &&
            main_osc_faster;
    endsequence
    sequence s_pd_arm;
        wr_run && pwr_wr_data[pmos_pkg::PD_ARM_BIT] && main_osc_faster;
    endsequence
    sequence s_pd_go;
        wr_run && pwr_wr_data[pmos_pkg::PD_GO_BIT] && main_osc_faster;
    endsequence

    a_idle_entry_pair: assert property (s_idle_arm ##1 s_idle_go |=> state_q == pmos_pkg::PMOS_IDLE)
        else $error("idle entry pair ignored");
    a_pd_entry_pair: assert property (s_pd_arm ##1 s_pd_go |=> state_q == pmos_pkg::PMOS_PDOWN)
        else $error("power-down entry pair ignored");
    a_lone_go_ignored: assert property (wr_run && !pcr_q[pmos_pkg::IDLE_ARM_BIT] &&
        !pcr_q[pmos_pkg::PD_ARM_BIT] |=> state_q != pmos_pkg::PMOS_IDLE &&
        state_q != pmos_pkg::PMOS_PDOWN)
        else $error("mode entered without arming write");
    a_idle_cpu_gate: assert property (state_q == pmos_pkg::PMOS_IDLE |-> !cpu_clk_en && wdt_halt)
        else $error("cpu clock or watchdog running in idle");
    a_pd_osc_off: assert property (state_q == pmos_pkg::PMOS_PDOWN |->
        !main_osc_en && !rc_osc_en && !periph_clk_en && wdt_halt)
        else $error("oscillator running in power-down");
    a_wake_pin_exit: assert property (state_q == pmos_pkg::PMOS_PDOWN && wake_low |=>
        state_q == pmos_pkg::PMOS_WAKE && main_osc_en && rc_osc_en && clk_sel_rc)
        else $error("wake pin did not restart oscillators");
    a_wake_irq_delay: assert property (pd_wake_irq |-> state_q == pmos_pkg::PMOS_RUN &&
        $past(state_q) == pmos_pkg::PMOS_WSTAB && $past(stab_cnt_q) == STAB_LAST)
        else $error("wake interrupt before stabilization");
    a_osc_fail_reset: assert property ((state_q == pmos_pkg::PMOS_RUN ||
        state_q == pmos_pkg::PMOS_IDLE) && !main_osc_faster |=> cpu_reset && clk_sel_rc)
        else $error("slow oscillator did not force reset");
    a_slow_clear: assert property (wr_run && !pwr_wr_data[pmos_pkg::SLOW_BIT] |=>
        !power_control_reg[pmos_pkg::SLOW_BIT])
        else $error("slow-down bit not cleared");
endmodule : pmos_supervisor
`default_nettype wire
